/* File: bench/flash_program_erase_sequencer_bench.sv */
// Bench joining core end and sequencer end through the register link
`default_nettype none
module flash_program_erase_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clk = 1'b0;
	logic                    rst_n = 1'b0;
	logic                    sys_rst_n = 1'b1;
	logic                    serial_mode = 1'b0;
	logic [7:0]              avs_address = 8'h00;
	logic                    avs_read = 1'b0;
	logic                    avs_write = 1'b0;
	logic [31:0]             avs_writedata = 32'h00000000;
	logic [31:0]             avs_readdata;
	logic                    avs_waitrequest;
	logic                    flash_active;
	flash_seq_pkg::op_kind_t flash_kind;
	logic [23:0]             flash_addr;
	logic                    flash_we;
	logic [5:0]              flash_widx;
	logic [23:0]             flash_wdata;
	logic                    act_seen = 1'b0;
	logic [5:0]              last_idx = 6'h00;
	int                      stall_cnt = 0;
	int                      we_cnt = 0;
	int                      failures = 0;
	int                      cmp_count = 0;

	always #10 clk = ~clk;

	flash_seq_if flash_seq_if_inst ();
	flash_core_controller flash_core_controller_inst (.CLK(clk), .RST_N(rst_n),
		.AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
		.AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .BUS(flash_seq_if_inst));
	// Short run lengths keep the row program above its 64 commits
	flash_program_erase_sequencer #(.WORD_CYCLES(70), .ROW_CYCLES(70), .ERASE_CYCLES(10))
		flash_program_erase_sequencer_inst (.CLK(clk), .RST_N(rst_n), .SYS_RST_N(sys_rst_n),
		.BUS(flash_seq_if_inst), .SERIAL_PROG_MODE(serial_mode), .FLASH_ACTIVE(flash_active),
		.FLASH_KIND(flash_kind), .FLASH_ADDR(flash_addr), .FLASH_WE(flash_we),
		.FLASH_WIDX(flash_widx), .FLASH_WDATA(flash_wdata));
	flash_seq_props #(.ROW_CYCLES(70), .ERASE_CYCLES(10))
		flash_seq_props_inst (.CLK(clk), .RST_N(rst_n), .wr(flash_seq_if_inst.wr),
		.sel(flash_seq_if_inst.sel), .wdata(flash_seq_if_inst.wdata),
		.rdata(flash_seq_if_inst.rdata), .stall(flash_seq_if_inst.stall));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Outputs are registered, so look at them mid-cycle
	always @(negedge clk) begin
		if (flash_seq_if_inst.stall === 1'b1)
			stall_cnt++;
		if (flash_active === 1'b1)
			act_seen = 1'b1;
		if (flash_we === 1'b1) begin
			we_cnt++;
			last_idx = flash_widx;
			check({8'h00, flash_wdata}, {8'h00, 18'h29400, flash_widx});
		end
	end

	task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		// Just after the edge the values that stood before it are still seen
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
		if (n >= 2000) begin
			failures++;
			$display("CHECK FAILED at %0t: no bus answer", $time);
			tally_and_finish;
		end
	endtask

	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		av(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		av(1'b0, a, 32'h00000000, q);
		check(q, exp);
	endtask

	task automatic t_reset;
		rd_chk(flash_seq_pkg::REG_STATUS, 32'h00000000);
		rd_chk(8'h20, 32'h00000000);
		wr32(8'h20, 32'hFFFFFFFF);
		rd_chk(flash_seq_pkg::REG_STATUS, 32'h00000000);
		// Locked start loads the control bits and flags the attempt
		wr32(flash_seq_pkg::REG_CMD, 32'h0000C143);
		rd_chk(flash_seq_pkg::REG_STATUS, 32'h60430002);
		sys_rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		sys_rst_n <= 1'b1;
		rd_chk(flash_seq_pkg::REG_STATUS, 32'h60430002);
	endtask

	task automatic t_refuse;
		// Key writes skipped, then keys given with enable clear
		wr32(flash_seq_pkg::REG_CMD, 32'h0000C103);
		rd_chk(flash_seq_pkg::REG_STATUS, 32'h60030002);
		wr32(flash_seq_pkg::REG_CMD, 32'h00008003);
		rd_chk(flash_seq_pkg::REG_STATUS, 32'h20030002);
		check({act_seen, 31'(stall_cnt)}, 32'h00000000);
	endtask

	task automatic t_ops;
		// Nibbles: serial mode, erase, expected kind, operation code
		// Page erase first, so the rows are rewritten into an erased block
		logic [15:0] tab [10] = '{16'h0132, 16'h0021, 16'h0013, 16'h114F, 16'h010F,
			16'h0002, 16'h0103, 16'h0101, 16'h000F, 16'h0005};
		logic [23:0] addr_exp [5] = '{24'h000000, 24'h000000, 24'h123780, 24'h123400,
			24'h000000};
		logic [15:0] e;
		logic [31:0] cmd;
		logic [31:0] st;
		int          len;
		wr32(flash_seq_pkg::REG_PAGE, 32'h00000012);
		wr32(flash_seq_pkg::REG_POINTER, 32'h000037D6);
		rd_chk(flash_seq_pkg::REG_POINTER, 32'h000037D6);
		wr32(flash_seq_pkg::REG_LATCH_IDX, 32'h00000000);
		for (int i = 0; i < 64; i++) begin
			wr32(flash_seq_pkg::REG_LATCH, {8'h00, 18'h29400, 6'(i)});
		end
		rd_chk(flash_seq_pkg::REG_LATCH_IDX, 32'h00000000);
		for (int i = 0; i < 10; i++) begin
			e = tab[i];
			serial_mode <= e[12];
			stall_cnt = 0;
			we_cnt = 0;
			act_seen = 1'b0;
			cmd = {16'h0000, 2'b11, 7'h00, e[8], 2'b00, e[3:0]};
			st = {3'b010, 6'h00, e[8], 2'b00, e[3:0], 16'h0000};
			wr32(flash_seq_pkg::REG_CMD, cmd);
			rd_chk(flash_seq_pkg::REG_STATUS, st);
			len = (e[7:4] == 4'h1 || e[7:4] == 4'h2) ? 70 : (e[7:4] == 4'h0 ? 1 : 10);
			check(act_seen, e[7:4] != 4'h0);
			check(we_cnt, e[7:4] == 4'h1 ? 1 : (e[7:4] == 4'h2 ? 64 : 0));
			check(stall_cnt >= len + 1 && stall_cnt <= len + 3, 32'h1);
			check(flash_kind, e[7:4]);
			if (e[7:4] >= 4'h2)
				check(flash_addr, addr_exp[e[6:4]]);
			if (e[7:4] == 4'h1)
				check(last_idx, 6'h2B);
		end
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset;
		t_refuse;
		t_ops;
		tally_and_finish;
	end
endmodule
`default_nettype wire

/* File: bench/flash_seq_props.sv */
// Checker on the register link between core end and sequencer end
`default_nettype none
module flash_seq_props #(
	parameter int unsigned WORD_CYCLES  = 100,
	parameter int unsigned ROW_CYCLES   = 200,
	parameter int unsigned ERASE_CYCLES = 400
) (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        wr,
	input  wire logic        sel,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] rdata,
	input  wire logic        stall
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned pr = (WORD_CYCLES > ROW_CYCLES) ? WORD_CYCLES : ROW_CYCLES;
	// Run, done cycle and launch edge, plus one cycle of slack
	localparam int unsigned limit = ((pr > ERASE_CYCLES) ? pr : ERASE_CYCLES) + 3;
	logic        got55;
	logic [7:0]  since_aa;
	logic [15:0] stall_run;
	logic        start_wr;

	assign start_wr = wr && !sel && wdata[flash_seq_pkg::CTL_START_BIT] && !stall;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			got55    <= 1'b0;
			since_aa <= 8'hFF;
		end else begin
			got55 <= wr && sel && wdata[7:0] == flash_seq_pkg::KEY_FIRST;
			if (wr && sel && got55 && wdata[7:0] == flash_seq_pkg::KEY_SECOND)
				since_aa <= 8'h00;
			else if (since_aa != 8'hFF)
				since_aa <= since_aa + 8'h01;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			stall_run <= 16'h0000;
		else
			stall_run <= stall ? stall_run + 16'h0001 : 16'h0000;
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_key55;
		wr && sel && wdata[7:0] == flash_seq_pkg::KEY_FIRST;
	endsequence
	sequence s_keyaa;
		wr && sel && wdata[7:0] == flash_seq_pkg::KEY_SECOND;
	endsequence
	sequence s_unlock;
		s_key55 ##1 s_keyaa;
	endsequence

	a_stall_is_start: assert property (stall == rdata[15])
		else $error("stall differs from start bit");
	a_reserved_zero: assert property (rdata[12:7] == 6'h00 && rdata[5:4] == 2'h0)
		else $error("unimplemented control bits not zero");
	a_locked_refuse: assert property (start_wr && since_aa > 8'h08
		|=> !stall && rdata[13])
		else $error("start accepted without unlock");
	a_disabled_refuse: assert property (start_wr && !wdata[14]
		|=> !stall && rdata[13])
		else $error("start accepted with enable clear");
	a_error_on_start: assert property (start_wr |=> rdata[13])
		else $error("error flag not set on start attempt");
	a_unlocked_run: assert property (s_unlock ##1 (start_wr && wdata[14])
		|=> stall [*2])
		else $error("unlocked start did not stall");
	a_stall_bounded: assert property (stall_run <= limit)
		else $error("start bit never cleared");
	a_no_write_stalled: assert property (stall |-> !wr)
		else $error("core wrote while stalled");
	a_setup_held: assert property (stall && $past(stall)
		|-> $stable(rdata[6:0]) && rdata[14])
		else $error("operation setup changed during run");
	a_ctl_loads: assert property (wr && !sel && !stall |=>
		rdata[6:0] == {$past(wdata[6]), 2'b00, $past(wdata[3:0])})
		else $error("control bits not loaded");
	a_done_clears_err: assert property ($fell(stall) |-> !rdata[13])
		else $error("error flag set after normal completion");
endmodule
`default_nettype wire

/* File: logic/flash_core_controller.sv */
// Core end: Avalon-MM registers driving the unlock and start sequence
`default_nettype none
module flash_core_controller (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic [7:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	flash_seq_if.core        BUS
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_CTL  = 3'b001,
		H_KEY1 = 3'b011,
		H_KEY2 = 3'b010,
		H_GO   = 3'b110,
		H_WAIT = 3'b111,
		H_END  = 3'b101
	} host_state_t;

	host_state_t hstate;
	logic        ack;
	logic        go_req;
	logic        take;
	logic [15:0] cmd_ctl;
	logic        skip_keys;
	logic [7:0]  page;
	logic [15:0] pointer;
	logic [5:0]  latch_idx;

	assign go_req = AVS_WRITE && AVS_ADDRESS == flash_seq_pkg::REG_CMD
		&& AVS_WRITEDATA[flash_seq_pkg::CMD_GO_BIT];
	assign take   = (AVS_READ || AVS_WRITE) && ack;
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
	assign BUS.tbl_addr    = {page, pointer};

	// A start command holds the bus until the operation ends
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ack <= 1'b0;
		end else if (go_req) begin
			ack <= hstate == H_END;
		end else begin
			ack <= (AVS_READ || AVS_WRITE) && !ack;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			AVS_READDATA <= 32'h00000000;
		end else if (AVS_READ && !ack) begin
			case (AVS_ADDRESS)
				flash_seq_pkg::REG_CMD:       AVS_READDATA <= {16'h0000, cmd_ctl};
				flash_seq_pkg::REG_STATUS:    AVS_READDATA <= {BUS.rdata, 14'h0000,
					BUS.rdata[flash_seq_pkg::CTL_ERROR_BIT], BUS.stall};
				flash_seq_pkg::REG_PAGE:      AVS_READDATA <= {24'h000000, page};
				flash_seq_pkg::REG_POINTER:   AVS_READDATA <= {16'h0000, pointer};
				flash_seq_pkg::REG_LATCH_IDX: AVS_READDATA <= {26'h0000000, latch_idx};
				default:                      AVS_READDATA <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			page      <= 8'h00;
			pointer   <= 16'h0000;
			latch_idx <= 6'h00;
		end else if (take && AVS_WRITE) begin
			case (AVS_ADDRESS)
				flash_seq_pkg::REG_PAGE:      page <= AVS_WRITEDATA[7:0];
				flash_seq_pkg::REG_POINTER:   pointer <= AVS_WRITEDATA[15:0];
				flash_seq_pkg::REG_LATCH_IDX: latch_idx <= AVS_WRITEDATA[5:0];
				flash_seq_pkg::REG_LATCH:     latch_idx <= latch_idx + 6'h01;
				default:                      latch_idx <= latch_idx;
			endcase
		end
	end

	// Latch loads go out as one-cycle table writes
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			BUS.tbl_we   <= 1'b0;
			BUS.tbl_idx  <= 6'h00;
			BUS.tbl_data <= 24'h000000;
		end else begin
			BUS.tbl_we <= take && AVS_WRITE && AVS_ADDRESS == flash_seq_pkg::REG_LATCH;
			if (take && AVS_WRITE && AVS_ADDRESS == flash_seq_pkg::REG_LATCH) begin
				BUS.tbl_idx  <= latch_idx;
				BUS.tbl_data <= AVS_WRITEDATA[23:0];
			end
		end
	end

	// Control, key 55h, key AAh, start, wait for stall to drop
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			hstate    <= H_IDLE;
			cmd_ctl   <= 16'h0000;
			skip_keys <= 1'b0;
			BUS.wr    <= 1'b0;
			BUS.sel   <= flash_seq_pkg::PORT_CONTROL;
			BUS.wdata <= 16'h0000;
		end else begin
			BUS.wr <= 1'b0;
			case (hstate)
				H_IDLE: if (go_req && !ack) begin
					cmd_ctl   <= AVS_WRITEDATA[15:0] & flash_seq_pkg::CMD_CTL_MASK;
					skip_keys <= AVS_WRITEDATA[flash_seq_pkg::CMD_SKIP_KEYS_BIT];
					BUS.wr    <= 1'b1;
					BUS.sel   <= flash_seq_pkg::PORT_CONTROL;
					BUS.wdata <= AVS_WRITEDATA[15:0] & flash_seq_pkg::CMD_CTL_MASK;
					hstate    <= H_CTL;
				end
				H_CTL: begin
					BUS.wr <= 1'b1;
					if (skip_keys) begin
						BUS.sel   <= flash_seq_pkg::PORT_CONTROL;
						BUS.wdata <= cmd_ctl | 16'h8000;
						hstate    <= H_GO;
					end else begin
						BUS.sel   <= flash_seq_pkg::PORT_KEY;
						BUS.wdata <= {8'h00, flash_seq_pkg::KEY_FIRST};
						hstate    <= H_KEY1;
					end
				end
				H_KEY1: begin
					BUS.wr    <= 1'b1;
					BUS.wdata <= {8'h00, flash_seq_pkg::KEY_SECOND};
					hstate    <= H_KEY2;
				end
				H_KEY2: begin
					BUS.wr    <= 1'b1;
					BUS.sel   <= flash_seq_pkg::PORT_CONTROL;
					BUS.wdata <= cmd_ctl | 16'h8000;
					hstate    <= H_GO;
				end
				H_GO:    hstate <= H_WAIT;
				H_WAIT:  if (!BUS.stall) hstate <= H_END;
				H_END:   hstate <= H_IDLE;
				default: hstate <= H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: logic/flash_program_erase_sequencer.sv */
// Device end: unlock keys, control register, latches, self-timed operation
`default_nettype none
module flash_program_erase_sequencer #(
	parameter int unsigned WORD_CYCLES  = flash_seq_pkg::WORD_PROG_CYCLES,
	parameter int unsigned ROW_CYCLES   = flash_seq_pkg::ROW_PROG_CYCLES,
	parameter int unsigned ERASE_CYCLES = flash_seq_pkg::ERASE_CYCLES
) (
	input  wire logic               CLK,
	input  wire logic               RST_N,
	input  wire logic               SYS_RST_N,
	flash_seq_if.seq                BUS,
	input  wire logic               SERIAL_PROG_MODE,
	output logic                    FLASH_ACTIVE,
	output flash_seq_pkg::op_kind_t FLASH_KIND,
	output logic [23:0]             FLASH_ADDR,
	output logic                    FLASH_WE,
	output logic [5:0]              FLASH_WIDX,
	output logic [23:0]             FLASH_WDATA
);
	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_HALF = 2'b01,
		KEY_OPEN = 2'b11
	} key_state_t;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_RUN  = 2'b01,
		SEQ_DONE = 2'b11
	} seq_state_t;

	logic                    serial_meta;
	logic                    serial_sync;
	key_state_t              key_state;
	logic [3:0]              window;
	seq_state_t              seq_state;
	logic                    start_bit;
	logic                    enable;
	logic                    error;
	logic                    erase;
	logic [3:0]              opsel;
	flash_seq_pkg::op_kind_t run_kind;
	logic [15:0]             run_cnt;
	logic [15:0]             run_len;
	logic [5:0]              word_idx;
	logic [23:0]             hold_latch [flash_seq_pkg::ROW_WORDS];
	logic                    key_wr;
	logic                    ctl_wr;
	logic                    start_try;
	logic                    start_ok;
	logic                    finish;

	function automatic flash_seq_pkg::op_kind_t decode(input logic [3:0] op,
		input logic ers, input logic serial);
		flash_seq_pkg::op_kind_t k;
		k = flash_seq_pkg::OP_NONE;
		case (op)
			flash_seq_pkg::OPC_WORD: if (!ers) k = flash_seq_pkg::OP_WORD;
			flash_seq_pkg::OPC_ROW:  if (!ers) k = flash_seq_pkg::OP_ROW;
			flash_seq_pkg::OPC_PAGE: if (ers) k = flash_seq_pkg::OP_PAGE;
			flash_seq_pkg::OPC_BULK: if (ers && serial) begin
				k = flash_seq_pkg::OP_BULK;
			end
			default: k = flash_seq_pkg::OP_NONE;
		endcase
		return k;
	endfunction

	function automatic logic [23:0] align(input logic [23:0] a,
		input flash_seq_pkg::op_kind_t k);
		case (k)
			flash_seq_pkg::OP_ROW:  return a & flash_seq_pkg::ROW_ALIGN;
			flash_seq_pkg::OP_PAGE: return a & flash_seq_pkg::BLOCK_ALIGN;
			flash_seq_pkg::OP_BULK: return 24'h000000;
			default:                return a;
		endcase
	endfunction

	function automatic logic [15:0] duration(input flash_seq_pkg::op_kind_t k);
		case (k)
			flash_seq_pkg::OP_WORD: return WORD_CYCLES[15:0];
			flash_seq_pkg::OP_ROW:  return ROW_CYCLES[15:0];
			flash_seq_pkg::OP_PAGE: return ERASE_CYCLES[15:0];
			flash_seq_pkg::OP_BULK: return ERASE_CYCLES[15:0];
			default:                return 16'h0001;
		endcase
	endfunction

	// Writes while busy cannot come from a stalled core; drop them
	assign key_wr    = BUS.wr && BUS.sel == flash_seq_pkg::PORT_KEY && !start_bit;
	assign ctl_wr    = BUS.wr && BUS.sel == flash_seq_pkg::PORT_CONTROL && !start_bit;
	assign start_try = ctl_wr && BUS.wdata[flash_seq_pkg::CTL_START_BIT];
	assign start_ok  = start_try && key_state == KEY_OPEN
		&& BUS.wdata[flash_seq_pkg::CTL_ENABLE_BIT];
	assign finish    = seq_state == SEQ_DONE;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			serial_meta <= 1'b0;
			serial_sync <= 1'b0;
		end else begin
			serial_meta <= SERIAL_PROG_MODE;
			serial_sync <= serial_meta;
		end
	end

	// Unlock needs two consecutive key writes, then expires quickly
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			key_state <= KEY_IDLE;
			window    <= 4'h0;
		end else if (!SYS_RST_N || start_try) begin
			key_state <= KEY_IDLE;
			window    <= 4'h0;
		end else if (key_wr) begin
			window <= flash_seq_pkg::UNLOCK_WINDOW;
			if (BUS.wdata[7:0] == flash_seq_pkg::KEY_SECOND && key_state == KEY_HALF) begin
				key_state <= KEY_OPEN;
			end else if (BUS.wdata[7:0] == flash_seq_pkg::KEY_FIRST) begin
				key_state <= KEY_HALF;
			end else begin
				key_state <= KEY_IDLE;
			end
		end else if (ctl_wr) begin
			key_state <= KEY_IDLE;
		end else if (key_state == KEY_OPEN) begin
			if (window == 4'h1) begin
				key_state <= KEY_IDLE;
			end
			window <= window - 4'h1;
		end
	end

	// Only power-on reset touches the control bits
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			enable <= flash_seq_pkg::CTL_RESET[flash_seq_pkg::CTL_ENABLE_BIT];
			erase  <= flash_seq_pkg::CTL_RESET[flash_seq_pkg::CTL_ERASE_BIT];
			opsel  <= flash_seq_pkg::CTL_RESET[3:0];
		end else if (ctl_wr) begin
			enable <= BUS.wdata[flash_seq_pkg::CTL_ENABLE_BIT];
			erase  <= BUS.wdata[flash_seq_pkg::CTL_ERASE_BIT];
			opsel  <= BUS.wdata[3:0];
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			start_bit <= flash_seq_pkg::CTL_RESET[flash_seq_pkg::CTL_START_BIT];
		end else if (start_ok) begin
			start_bit <= 1'b1;
		end else if (finish) begin
			start_bit <= 1'b0;
		end
	end

	// Any start attempt flags, cleared again by normal completion
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			error <= flash_seq_pkg::CTL_RESET[flash_seq_pkg::CTL_ERROR_BIT];
		end else if (start_try) begin
			error <= 1'b1;
		end else if (finish) begin
			error <= 1'b0;
		end else if (ctl_wr) begin
			error <= BUS.wdata[flash_seq_pkg::CTL_ERROR_BIT];
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			seq_state  <= SEQ_IDLE;
			run_kind   <= flash_seq_pkg::OP_NONE;
			run_cnt    <= 16'h0000;
			run_len    <= 16'h0001;
			FLASH_ADDR <= 24'h000000;
			word_idx   <= 6'h00;
		end else begin
			case (seq_state)
				SEQ_IDLE: if (start_ok) begin
					seq_state  <= SEQ_RUN;
					run_kind   <= decode(BUS.wdata[3:0],
						BUS.wdata[flash_seq_pkg::CTL_ERASE_BIT], serial_sync);
					run_len    <= duration(decode(BUS.wdata[3:0],
						BUS.wdata[flash_seq_pkg::CTL_ERASE_BIT], serial_sync));
					FLASH_ADDR <= align(BUS.tbl_addr, decode(BUS.wdata[3:0],
						BUS.wdata[flash_seq_pkg::CTL_ERASE_BIT], serial_sync));
					word_idx   <= BUS.tbl_addr[6:1];
					run_cnt    <= 16'h0000;
				end
				SEQ_RUN: begin
					run_cnt <= run_cnt + 16'h0001;
					if (run_cnt == run_len - 16'h0001) begin
						seq_state <= SEQ_DONE;
					end
				end
				SEQ_DONE: seq_state <= SEQ_IDLE;
				default:  seq_state <= SEQ_IDLE;
			endcase
		end
	end

	// Latches hold data only; no reset needed
	always_ff @(posedge CLK) begin
		if (BUS.tbl_we && !start_bit) begin
			hold_latch[BUS.tbl_idx] <= BUS.tbl_data;
		end
	end

	// Commit latched words while the program operation runs
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			FLASH_WE    <= 1'b0;
			FLASH_WIDX  <= 6'h00;
			FLASH_WDATA <= 24'h000000;
		end else if (seq_state == SEQ_RUN && run_kind == flash_seq_pkg::OP_ROW
			&& run_cnt < 16'(flash_seq_pkg::ROW_WORDS)) begin
			FLASH_WE    <= 1'b1;
			FLASH_WIDX  <= run_cnt[5:0];
			FLASH_WDATA <= hold_latch[run_cnt[5:0]];
		end else if (seq_state == SEQ_RUN && run_kind == flash_seq_pkg::OP_WORD
			&& run_cnt == 16'h0000) begin
			FLASH_WE    <= 1'b1;
			FLASH_WIDX  <= word_idx;
			FLASH_WDATA <= hold_latch[word_idx];
		end else begin
			FLASH_WE <= 1'b0;
		end
	end

	assign FLASH_ACTIVE = seq_state == SEQ_RUN && run_kind != flash_seq_pkg::OP_NONE;
	assign FLASH_KIND   = run_kind;
	assign BUS.stall    = start_bit;
	assign BUS.rdata    = {start_bit, enable, error, 6'h00, erase, 2'h0, opsel};
endmodule
`default_nettype wire

/* File: logic/flash_seq_if.sv */
// Register and table-write port between processor core and sequencer
`default_nettype none
interface flash_seq_if;
	logic        wr;
	logic        sel;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        stall;
	logic        tbl_we;
	logic [5:0]  tbl_idx;
	logic [23:0] tbl_data;
	logic [23:0] tbl_addr;

	modport core (output wr, sel, wdata, tbl_we, tbl_idx, tbl_data, tbl_addr,
		input rdata, stall);
	modport seq (input wr, sel, wdata, tbl_we, tbl_idx, tbl_data, tbl_addr,
		output rdata, stall);
endinterface
`default_nettype wire

/* File: logic/flash_seq_pkg.sv */
// Constants, encodings and types shared by the core and sequencer ends
// Functional notes
// - Software writes 55h then AAh before start
// - No operation starts without the unlock sequence
// - Core stalls for the whole operation
// - Start bit 15 launches; hardware clears it
// - Start bit is set-only; zero means idle
// - Enable bit 14 clear inhibits every operation
// - Error bit 13 set on improper start attempt
// - Erase bit 6 selects erase or program variant
// - Codes 0011 word, 0001 row program, erase clear
// - Codes 0010 page, 1111 bulk erase, erase set
// - Bulk erase only in serial programming mode
// - Other operation codes perform no operation
// - Control bits reset only at power-on
// - Bits 12-7 and 5-4 read as zero
// - Erase the eight-row block before rewriting rows
// - Block erase: code 0010, erase, enable, keys, start
// - Row program: load 64 words, code 0001, keys, start
// - Two idle instructions follow the start write
// - Table writes sit in latches until commit
// - Blocks aligned on 1536 and 192 byte bounds
`default_nettype none
package flash_seq_pkg;
	localparam int  CTL_START_BIT   = 15;
	localparam int  CTL_ENABLE_BIT  = 14;
	localparam int  CTL_ERROR_BIT   = 13;
	localparam int  CTL_ERASE_BIT   = 6;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [7:0]  KEY_FIRST  = 8'h55;
	localparam logic [7:0]  KEY_SECOND = 8'hAA;
	localparam logic [3:0]  OPC_ROW  = 4'h1;
	localparam logic [3:0]  OPC_PAGE = 4'h2;
	localparam logic [3:0]  OPC_WORD = 4'h3;
	localparam logic [3:0]  OPC_BULK = 4'hF;
	localparam logic        PORT_CONTROL = 1'b0;
	localparam logic        PORT_KEY     = 1'b1;
	localparam int  ROW_WORDS        = 64;
	// Two address units per instruction: 192 and 1536 byte blocks
	localparam logic [23:0] ROW_ALIGN   = 24'hFFFF80;
	localparam logic [23:0] BLOCK_ALIGN = 24'hFFFC00;
	localparam logic [3:0]  UNLOCK_WINDOW = 4'h4;
	localparam int  WORD_PROG_CYCLES = 100;
	localparam int  ROW_PROG_CYCLES  = 200;
	localparam int  ERASE_CYCLES     = 400;
	localparam logic [7:0] REG_CMD       = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam logic [7:0] REG_PAGE      = 8'h08;
	localparam logic [7:0] REG_POINTER   = 8'h0C;
	localparam logic [7:0] REG_LATCH     = 8'h10;
	localparam logic [7:0] REG_LATCH_IDX = 8'h14;
	localparam int  CMD_GO_BIT        = 15;
	localparam int  CMD_SKIP_KEYS_BIT = 8;
	localparam logic [15:0] CMD_CTL_MASK = 16'h404F;

	typedef enum logic [2:0] {
		OP_NONE, OP_WORD, OP_ROW, OP_PAGE, OP_BULK
	} op_kind_t;
endpackage
`default_nettype wire
